// [dv/cefu_partner.sv]
// Partner model: free-running system counter and on-chip event lines.
// Assumes the bench asks for one-cycle events by flag index.
`timescale 1ns/1ps
`default_nettype none
module cefu_partner (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Event requests by flag index
  input wire logic [15:0] ev_req,
  // Counter and event lines
  output logic [31:0] system_counter,
  output logic attention_event,
  output logic fifo_block_wrap_event,
  output logic interrupt_event,
  output logic queue_empty_event,
  output logic streamer_event_a,
  output logic streamer_event_b,
  output logic streamer_event_c,
  output logic streamer_event_d
);
  logic [31:0] cnt_q;
  // Counter never stops, so a target is met once per wrap
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) cnt_q <= 32'h0000_0000;
    else cnt_q <= cnt_q + 32'h0000_0001;
  end
  assign system_counter = cnt_q;
  assign attention_event = ev_req[0];
  assign fifo_block_wrap_event = ev_req[4];
  assign interrupt_event = ev_req[5];
  assign queue_empty_event = ev_req[7];
  assign {streamer_event_d, streamer_event_c} = ev_req[15:14];
  assign {streamer_event_b, streamer_event_a} = ev_req[13:12];
endmodule
`default_nettype wire

// [dv/tb_top.sv]
// Bench of the event flag unit: commands, event flags, registers, irq.
// Assumes the partner model drives the counter and the event lines.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic sys_clk, rst, ce, cmd_valid, cmd_ready, rsp_valid, irq;
  cefu_pkg::cefu_cmd_type cmd;
  cefu_pkg::cefu_rsp_type rsp, r;
  logic [15:0] ev_req, strobe_cog_attention, mflag;
  logic [31:0] system_counter, pin_input_low_port, pin_input_high_port;
  logic attention_event, fifo_block_wrap_event, interrupt_event;
  logic queue_empty_event, streamer_event_a, streamer_event_b;
  logic streamer_event_c, streamer_event_d;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready;
  logic [31:0] s_axi_wdata, s_axi_rdata, dv, sv, rv;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  int n_mismatch, cmp_count, lat;
  int evs[8] = '{0, 4, 5, 7, 12, 13, 14, 15};

  cefu_top u_cefu_top (.sys_clk, .rst, .ce, .cmd_valid, .cmd_ready, .cmd,
    .rsp_valid, .rsp, .system_counter, .pin_input_low_port,
    .pin_input_high_port, .attention_event, .fifo_block_wrap_event,
    .interrupt_event, .queue_empty_event, .streamer_event_a,
    .streamer_event_b, .streamer_event_c, .streamer_event_d,
    .strobe_cog_attention, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .irq);
  cefu_partner u_cefu_partner (.sys_clk, .rst, .ev_req, .system_counter,
    .attention_event, .fifo_block_wrap_event, .interrupt_event,
    .queue_empty_event, .streamer_event_a, .streamer_event_b,
    .streamer_event_c, .streamer_event_d);

  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  task automatic give_verdict;
    $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic hang(input string m);
    $display("[FAIL] %0t timeout %s", $time, m);
    n_mismatch++;
    give_verdict();
  endtask

  task automatic chk(input logic [31:0] got, exp, input string m);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  // One command; f is {wr_c, wr_z, c_in, z_in}; lat counts edges to rsp
  task automatic issue(input cefu_pkg::cefu_op_type o, input logic [3:0] k,
                       input logic [31:0] d, s, input logic [3:0] f);
    int n;
    @(posedge sys_clk);
    cmd_valid <= 1'b1;
    cmd <= '{o, k, d, s, f[3], f[2], f[1], f[0]};
    n = 0;
    do begin
      @(negedge sys_clk);
      n++;
    end while (cmd_ready !== 1'b1 && n < 500);
    if (n >= 500) hang("cmd");
    @(posedge sys_clk);
    cmd_valid <= 1'b0;
    lat = 0;
    do begin
      @(negedge sys_clk);
      lat++;
    end while (rsp_valid !== 1'b1 && lat < 500);
    if (lat >= 500) hang("rsp");
    r = rsp;
  endtask

  task automatic fire(input int k);
    @(posedge sys_clk);
    ev_req[k] <= 1'b1;
    @(posedge sys_clk);
    ev_req[k] <= 1'b0;
    mflag[k] = 1'b1;
  endtask

  task automatic pins(input logic [31:0] lo, hi);
    @(posedge sys_clk);
    pin_input_low_port <= lo;
    pin_input_high_port <= hi;
    repeat (4) @(posedge sys_clk);
  endtask

  task automatic poll(input int k, input logic [3:0] f);
    issue(cefu_pkg::OP_POLL_CLEAR, 4'(k), 0, 0, f);
    chk(32'(lat), 1, "poll time");
    chk({r.wr_c, r.wr_z, r.c, r.z}, {f[3:2], {2{mflag[k]}}}, "poll");
    mflag[k] = 1'b0;
  endtask

  task automatic jmp(input int k);
    sv = $urandom;
    issue(cefu_pkg::OP_JUMP_IF_SET, 4'(k), 0, sv, 4'h0);
    chk({r.jump, 5'(lat)}, {mflag[k], mflag[k] ? 5'h03 : 5'h01}, "js");
    issue(cefu_pkg::OP_JUMP_IF_CLEAR, 4'(k), 0, sv, 4'h0);
    chk({r.jump, 5'(lat)}, {~mflag[k], mflag[k] ? 5'h01 : 5'h03}, "jc");
    chk(r.target, sv, "jump target");
  endtask

  task automatic wt(input int k, input logic tmo);
    issue(cefu_pkg::OP_WAIT_CLEAR, 4'(k), 0, 0, 4'hc);
    chk({r.wr_c, r.wr_z, r.c, r.z}, {2'h3, {2{tmo}}}, "wait cz");
    mflag[k] = 1'b0;
  endtask

  task automatic axw(input logic [7:0] a, input logic [31:0] v);
    int n;
    logic ha, hw;
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    n = 0;
    do begin
      @(negedge sys_clk);
      ha = s_axi_awready === 1'b1 && s_axi_awvalid;
      hw = s_axi_wready === 1'b1 && s_axi_wvalid;
      @(posedge sys_clk);
      if (ha) s_axi_awvalid <= 1'b0;
      if (hw) s_axi_wvalid <= 1'b0;
      n++;
    end while (((s_axi_awvalid && !ha) || (s_axi_wvalid && !hw)) && n < 99);
    do begin
      @(negedge sys_clk);
      n++;
    end while (s_axi_bvalid !== 1'b1 && n < 200);
    if (n >= 200) hang("write");
    rs = s_axi_bresp;
    @(posedge sys_clk);
    s_axi_bready <= 1'b0;
  endtask

  task automatic axr(input logic [7:0] a);
    int n;
    @(posedge sys_clk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    n = 0;
    do begin
      @(negedge sys_clk);
      n++;
    end while (s_axi_arready !== 1'b1 && n < 99);
    @(posedge sys_clk);
    s_axi_arvalid <= 1'b0;
    do begin
      @(negedge sys_clk);
      n++;
    end while (s_axi_rvalid !== 1'b1 && n < 200);
    if (n >= 200) hang("read");
    rv = s_axi_rdata;
    rs = s_axi_rresp;
    @(posedge sys_clk);
    s_axi_rready <= 1'b0;
  endtask

  initial begin
    {rst, ce, cmd_valid, cmd, ev_req, mflag} = '0;
    rst = 1'b1;
    ce = 1'b1;
    {pin_input_low_port, pin_input_high_port} = 64'h0000_0000_0000_0000;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
    {s_axi_arvalid, s_axi_rready} = 2'h0;
    s_axi_wstrb = 4'hf;
    n_mismatch = 0;
    cmp_count = 0;
    void'($urandom(32'ha6df_bc15));
    repeat (8) @(posedge sys_clk);
    rst <= 1'b0;
    for (int k = 0; k < 16; k++) issue(cefu_pkg::OP_POLL_CLEAR, 4'(k), 0, 0, 4'h0);
    // Quiet flags, then each event line's flag alone
    for (int k = 0; k < 16; k++) begin
      poll(k, 4'hc);
      jmp(k);
    end
    foreach (evs[i]) begin
      fire(evs[i]);
      jmp(evs[i]);
      poll(evs[i], {2'(i % 3 + 1), 2'h0});
      poll(evs[i], 4'hc);
    end
    // Counter targets
    for (int t = 1; t < 4; t++) begin
      dv = system_counter + 32'h0000_0014;
      sv = $urandom % 8;
      issue(cefu_pkg::OP_ADVANCE_TARGET, 4'(t - 1), dv, sv, 4'h0);
      chk({r.wr_d, 5'(lat)}, {1'b1, 5'h01}, "adv time");
      chk(r.result, dv + sv, "adv sum");
      repeat (40) @(posedge sys_clk);
      mflag[t] = 1'b1;
      jmp(t);
      wt(t, 1'b0);
      chk(32'(lat), 1, "wait on set flag");
      poll(t, 4'hc);
    end
    // Stalled wait, then a timed-out wait
    fork
      wt(5, 1'b0);
      begin
        repeat (6) @(posedge sys_clk);
        fire(5);
      end
    join
    chk(32'(lat > 2), 1, "wait stall");
    poll(5, 4'hc);
    dv = system_counter + 32'h0000_0010;
    issue(cefu_pkg::OP_PREFIX_Q, 4'h0, dv, dv, 4'h0);
    wt(7, 1'b1);
    chk(32'(lat > 2), 1, "wait timeout");
    repeat (4) begin
      dv = $urandom;
      issue(cefu_pkg::OP_STROBE_ATTENTION, 4'h0, dv, 0, 4'h0);
      chk(32'(strobe_cog_attention), 32'(dv[15:0]), "strobe");
    end
    // Pin match: low port equal, then high port not equal
    issue(cefu_pkg::OP_SET_PIN_MATCH, 4'h0, 32'h0000_00ff, 32'h0000_005a, 4'h0);
    pins(32'h0000_0000, 32'h0000_005a);
    poll(6, 4'hc);
    pins(32'h1234_565a, 32'h0000_0003);
    mflag[6] = 1'b1;
    poll(6, 4'hc);
    issue(cefu_pkg::OP_SET_PIN_MATCH, 4'h0, 32'h0000_000f, 32'h0000_0003, 4'h3);
    poll(6, 4'hc);
    pins(32'h1234_565a, 32'h0000_0004);
    mflag[6] = 1'b1;
    poll(6, 4'hc);
    // Selectable: level high on pin 2, rising edge on pin 40
    issue(cefu_pkg::OP_CONFIG_SELECT, 4'h0, 32'hffff_ff02, 0, 4'h0);
    chk(32'(lat), 1, "cfg time");
    issue(cefu_pkg::OP_CONFIG_SELECT, 4'h1, 32'hfff0_fe68, 0, 4'h0);
    pins(32'h1234_565a, 32'h0000_0004);
    poll(8, 4'hc);
    poll(9, 4'hc);
    pins(32'h1234_565e, 32'h0000_0104);
    mflag[9:8] = 2'h3;
    poll(8, 4'hc);
    poll(9, 4'hc);
    // Registers and interrupt
    axw(8'h04, 32'hffff_ffff);
    axr(8'h04);
    chk({rs, rv}, {2'h0, 32'h0000_ffff}, "mask");
    axw(8'h04, 32'h0000_0000);
    axr(8'h00);
    fire(0);
    repeat (2) @(negedge sys_clk);
    chk(irq, 0, "irq masked");
    axw(8'h04, 32'h0000_0001);
    @(negedge sys_clk);
    chk(irq, 1, "irq raised");
    axr(8'h00);
    chk(rv & 32'h0000_0001, 1, "status");
    @(negedge sys_clk);
    chk(irq, 0, "irq cleared");
    axr(8'h08);
    chk(rv[0], mflag[0], "flags");
    axr(8'h40);
    chk(rs, 2'h2, "unmapped read");
    axw(8'h40, 32'h0000_0000);
    chk(rs, 2'h2, "unmapped write");
    give_verdict();
  end
endmodule
`default_nettype wire

// [logic/cefu_sel_evt.sv]
// Selectable event detector on one pin of the 64-bit input bus.
// Assumes pins are synchronous to sys_clk.
`include "cefu_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module cefu_sel_evt (
  // Clock, reset and enable
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic ce,
  // Configuration and pins
  input wire logic [`CEFU_SEL_CFG_W-1:0] cfg,
  input wire logic [63:0] pins,
  // Registered event hit: a pulse in edge modes, a level in modes 4 and 5
  output logic hit_q
);
  logic [2:0] mode;
  logic level;
  logic prev_q;
  logic hit_d;
  assign mode = cfg[`CEFU_SEL_MODE_HI:`CEFU_SEL_MODE_LO];
  assign level = pins[cfg[5:0]];
  // Mode 1 rise, 2 fall, 3 edge, 4 high, 5 low, else off
  assign hit_d = (mode == 3'h1) ? (level & ~prev_q) :
                 (mode == 3'h2) ? (~level & prev_q) :
                 (mode == 3'h3) ? (level ^ prev_q) :
                 (mode == 3'h4) ? level :
                 (mode == 3'h5) ? ~level : 1'b0;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      prev_q <= 1'b0;
      hit_q <= 1'b0;
    end else if (ce) begin
      prev_q <= level;
      hit_q <= hit_d;
    end
  end
endmodule
`default_nettype wire

// [logic/cefu_top.sv]
// Event flag unit of one processor, with AXI4-Lite status registers.
// Assumes a pipeline that issues one command and takes one response.
// Contract
// [RQ1] Advance target loads D+S, writes it back
// [RQ2] Attention strobe pulses cogs in D mask
// [RQ3] Jump if flag set; two or four clocks
// [RQ4] Jump if flag clear, same timing
// [RQ5] Poll copies flag to C/Z, clears it
// [RQ6] Pin match: C picks port, Z picks compare
// [RQ7] Pin match: D is mask, S is value
// [RQ8] Select config stores D low nine bits
// [RQ9] Wait stalls until flag, then clears it
// [RQ10] Q prefix gives wait timeout, shown in C/Z
// [RQ11] All sixteen flags jump, poll, wait alike
// [RQ12] Counter match sets flag until cleared
// [RQ13] No prefix waits forever; arrival no timeout
`include "cefu_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module cefu_top #(
  parameter int COGS = 16,
  parameter int ADDR_W = 8
) (
  // Clock, reset, enable
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic ce,
  // Command and response
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire cefu_pkg::cefu_cmd_type cmd,
  output logic rsp_valid,
  output var cefu_pkg::cefu_rsp_type rsp,
  // Event sources and attention strobe output
  input wire logic [31:0] system_counter,
  input wire logic [31:0] pin_input_low_port,
  input wire logic [31:0] pin_input_high_port,
  input wire logic attention_event,
  input wire logic fifo_block_wrap_event,
  input wire logic interrupt_event,
  input wire logic queue_empty_event,
  input wire logic streamer_event_a,
  input wire logic streamer_event_b,
  input wire logic streamer_event_c,
  input wire logic streamer_event_d,
  output logic [COGS-1:0] strobe_cog_attention,
  // AXI4-Lite slave
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Interrupt
  output logic irq
);
  initial begin
    if (COGS < 1 || COGS > 16) $error("COGS must be 1 to 16");
    if (ADDR_W < 4 || ADDR_W > 8) $error("ADDR_W must be 4 to 8");
  end

  function automatic logic flag_at(logic [15:0] f, logic [3:0] i);
    return f[i];
  endfunction
  function automatic logic [15:0] one_hot(logic [3:0] i);
    return 16'h0001 << i;
  endfunction

  cefu_pkg::cefu_state_type state_q;
  logic [15:0] flags_q, set_v, clr_v, status_q, mask_q;
  logic [31:0] tgt_q [3];
  logic [31:0] pin_mask_q, pin_value_q, q_val_q;
  logic pin_high_q, pin_ne_q, pin_prev_q, q_armed_q, tmo_en_q;
  logic [`CEFU_SEL_CFG_W-1:0] sel_cfg_q [4];
  logic [3:0] sel_hit;
  logic [1:0] delay_q;
  logic [3:0] wsel_q;
  logic [63:0] pins;
  logic take, flag_now, jump_taken, pin_now, wait_flag, wait_tmo;
  logic wait_done_now, adv_ok;
  logic [31:0] sum;

  assign cmd_ready = (state_q == cefu_pkg::ST_IDLE);
  assign take = cmd_valid & cmd_ready;
  assign flag_now = flag_at(flags_q, cmd.sel);
  assign sum = cmd.d + cmd.s;
  assign adv_ok = (cmd.sel[1:0] != 2'h3);
  assign jump_taken = (cmd.op == cefu_pkg::OP_JUMP_IF_SET) ? flag_now :
                      (cmd.op == cefu_pkg::OP_JUMP_IF_CLEAR) ? ~flag_now :
                      1'b0; // [RQ3] [RQ4] [RQ11]
  assign pins = {pin_input_high_port, pin_input_low_port};
  // Pin match compare, equal or not equal
  assign pin_now = (((pin_high_q ? pin_input_high_port :
                      pin_input_low_port) & pin_mask_q) == pin_value_q)
                   ^ pin_ne_q; // [RQ6] [RQ7]
  assign wait_flag = flag_at(flags_q, wsel_q);
  assign wait_tmo = tmo_en_q & (system_counter == q_val_q); // [RQ10]
  assign wait_done_now = take & (cmd.op == cefu_pkg::OP_WAIT_CLEAR) &
                         flag_now;

  // Selectable event detectors
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_sel
      cefu_sel_evt u_sel (
        .sys_clk(sys_clk),
        .rst(rst),
        .ce(ce),
        .cfg(sel_cfg_q[gi]),
        .pins(pins),
        .hit_q(sel_hit[gi])
      );
    end
  endgenerate

  // Flag set sources
  always_comb begin
    set_v = 16'h0000;
    set_v[`CEFU_FLAG_ATTENTION] = attention_event;
    for (int i = 0; i < 3; i++) begin
      set_v[`CEFU_FLAG_MATCH_BASE + i] = (system_counter == tgt_q[i]);
    end // [RQ12]
    set_v[`CEFU_FLAG_FIFO_WRAP] = fifo_block_wrap_event;
    set_v[`CEFU_FLAG_INTERRUPT] = interrupt_event;
    set_v[`CEFU_FLAG_PIN_MATCH] = pin_now & ~pin_prev_q;
    set_v[`CEFU_FLAG_QUEUE_EMPTY] = queue_empty_event;
    for (int i = 0; i < 4; i++) begin
      set_v[`CEFU_FLAG_SELECT_BASE + i] = sel_hit[i];
    end
    set_v[`CEFU_FLAG_STREAM_BASE + 0] = streamer_event_a;
    set_v[`CEFU_FLAG_STREAM_BASE + 1] = streamer_event_b;
    set_v[`CEFU_FLAG_STREAM_BASE + 2] = streamer_event_c;
    set_v[`CEFU_FLAG_STREAM_BASE + 3] = streamer_event_d;
  end

  // Flag clears by poll and wait
  always_comb begin
    clr_v = 16'h0000;
    if (take && (cmd.op == cefu_pkg::OP_POLL_CLEAR || wait_done_now)) begin
      clr_v = one_hot(cmd.sel); // [RQ5] [RQ9] [RQ11]
    end
    if (state_q == cefu_pkg::ST_WAIT && wait_flag) begin
      clr_v = one_hot(wsel_q); // [RQ9]
    end
  end

  // Flags: a set in the clear cycle wins
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      flags_q <= 16'h0000;
      pin_prev_q <= 1'b0;
    end else if (ce) begin
      flags_q <= (flags_q & ~clr_v) | set_v; // [RQ12]
      pin_prev_q <= pin_now;
    end
  end

  // Configuration written by commands
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < 3; i++) tgt_q[i] <= `CEFU_ZERO32;
      for (int i = 0; i < 4; i++) sel_cfg_q[i] <= '0;
      pin_mask_q <= `CEFU_ZERO32;
      pin_value_q <= `CEFU_ZERO32;
      pin_high_q <= 1'b0;
      pin_ne_q <= 1'b0;
      q_val_q <= `CEFU_ZERO32;
      q_armed_q <= 1'b0;
      strobe_cog_attention <= '0;
    end else if (ce) begin
      strobe_cog_attention <= '0;
      if (take) begin
        q_armed_q <= (cmd.op == cefu_pkg::OP_PREFIX_Q);
        unique case (cmd.op)
          cefu_pkg::OP_ADVANCE_TARGET: begin
            if (adv_ok) tgt_q[cmd.sel[1:0]] <= sum; // [RQ1]
          end
          cefu_pkg::OP_STROBE_ATTENTION: begin
            strobe_cog_attention <= cmd.d[COGS-1:0]; // [RQ2]
          end
          cefu_pkg::OP_SET_PIN_MATCH: begin
            pin_high_q <= cmd.c_in; // [RQ6]
            pin_ne_q <= cmd.z_in; // [RQ6]
            pin_mask_q <= cmd.d; // [RQ7]
            pin_value_q <= cmd.s; // [RQ7]
          end
          cefu_pkg::OP_CONFIG_SELECT: begin
            sel_cfg_q[cmd.sel[1:0]] <= cmd.d[`CEFU_SEL_CFG_W-1:0]; // [RQ8]
          end
          cefu_pkg::OP_PREFIX_Q: q_val_q <= cmd.d; // [RQ10]
          default: ;
        endcase
      end
    end
  end

  // Sequencer and response
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_q <= cefu_pkg::ST_IDLE;
      rsp_valid <= 1'b0;
      rsp <= '0;
      delay_q <= 2'h0;
      wsel_q <= 4'h0;
      tmo_en_q <= 1'b0;
    end else if (ce) begin
      rsp_valid <= 1'b0;
      unique case (state_q)
        cefu_pkg::ST_IDLE: begin
          if (take) begin
            rsp <= '0;
            rsp.target <= cmd.s;
            rsp.wr_c <= cmd.write_carry_flag;
            rsp.wr_z <= cmd.write_zero_flag;
            if (cmd.op == cefu_pkg::OP_ADVANCE_TARGET) begin
              rsp.result <= sum; // [RQ1]
              rsp.wr_d <= 1'b1;
            end
            if (cmd.op == cefu_pkg::OP_POLL_CLEAR) begin
              rsp.c <= flag_now; // [RQ5]
              rsp.z <= flag_now; // [RQ5]
            end
            if (jump_taken) begin
              rsp.jump <= 1'b1;
              delay_q <= `CEFU_JUMP_EXTRA; // [RQ3] [RQ4]
              state_q <= cefu_pkg::ST_JUMP;
            end else if (cmd.op == cefu_pkg::OP_WAIT_CLEAR && !flag_now) begin
              wsel_q <= cmd.sel;
              tmo_en_q <= q_armed_q; // [RQ13]
              state_q <= cefu_pkg::ST_WAIT; // [RQ9]
            end else begin
              rsp_valid <= 1'b1;
            end
          end
        end
        cefu_pkg::ST_JUMP: begin
          delay_q <= delay_q - 2'h1;
          if (delay_q == 2'h1) begin
            rsp_valid <= 1'b1;
            state_q <= cefu_pkg::ST_IDLE;
          end
        end
        cefu_pkg::ST_WAIT: begin
          if (wait_flag || wait_tmo) begin
            rsp.c <= ~wait_flag; // [RQ10] [RQ13]
            rsp.z <= ~wait_flag; // [RQ10] [RQ13]
            rsp_valid <= 1'b1;
            state_q <= cefu_pkg::ST_IDLE;
          end
        end
        default: state_q <= cefu_pkg::ST_IDLE;
      endcase
    end
  end

  // AXI4-Lite slave
  logic aw_got_q, w_got_q;
  logic [ADDR_W-1:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic do_write, rd_take, rd_status;
  logic [7:0] waddr8, raddr8;
  logic [31:0] rd_word;
  logic [15:0] status_clr;

  assign s_axi_awready = ~aw_got_q & ~s_axi_bvalid;
  assign s_axi_wready = ~w_got_q & ~s_axi_bvalid;
  assign do_write = aw_got_q & w_got_q & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;
  assign rd_take = s_axi_arvalid & s_axi_arready;
  assign waddr8 = 8'(awaddr_q);
  assign raddr8 = 8'(s_axi_araddr);
  assign rd_status = rd_take & (raddr8 == `CEFU_REG_STATUS);
  assign status_clr = rd_status ? 16'hffff : 16'h0000;
  assign rd_word = (raddr8 == `CEFU_REG_STATUS) ? {16'h0000, status_q} :
                   (raddr8 == `CEFU_REG_MASK) ? {16'h0000, mask_q} :
                   (raddr8 == `CEFU_REG_FLAGS) ? {16'h0000, flags_q} :
                   {28'h000_0000, tmo_en_q, q_armed_q, state_q};
  assign irq = |(status_q & mask_q);

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= `CEFU_ZERO32;
      wstrb_q <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `CEFU_RESP_OKAY;
      mask_q <= 16'h0000;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_got_q <= 1'b0;
        w_got_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= `CEFU_RESP_OKAY;
        if (waddr8 == `CEFU_REG_MASK) begin
          if (wstrb_q[0]) mask_q[7:0] <= wdata_q[7:0];
          if (wstrb_q[1]) mask_q[15:8] <= wdata_q[15:8];
        end else if (waddr8 != `CEFU_REG_STATUS &&
                     waddr8 != `CEFU_REG_FLAGS &&
                     waddr8 != `CEFU_REG_UNIT) begin
          s_axi_bresp <= `CEFU_RESP_SLVERR;
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= `CEFU_ZERO32;
      s_axi_rresp <= `CEFU_RESP_OKAY;
      status_q <= 16'h0000;
    end else if (ce) begin
      status_q <= (status_q & ~status_clr) | set_v;
      if (rd_take) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_word;
        s_axi_rresp <= (raddr8 > `CEFU_REG_UNIT || raddr8[1:0] != 2'h0) ?
                       `CEFU_RESP_SLVERR : `CEFU_RESP_OKAY;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst || !ce);
  logic is_take_adv, is_take_poll;
  assign is_take_adv = take & (cmd.op == cefu_pkg::OP_ADVANCE_TARGET);
  assign is_take_poll = take & (cmd.op == cefu_pkg::OP_POLL_CLEAR);

  adv_sum_a: assert property (is_take_adv |=> rsp_valid && rsp.wr_d && // [RQ1]
      rsp.result == $past(cmd.d) + $past(cmd.s)) else $error("advance sum");
  atn_pulse_a: assert property (take && // [RQ2]
      cmd.op == cefu_pkg::OP_STROBE_ATTENTION |=> strobe_cog_attention ==
      $past(cmd.d[COGS-1:0]) ##1 strobe_cog_attention == '0)
    else $error("attention strobe");
  jump_set_a: assert property (take && flag_now && // [RQ3]
      cmd.op == cefu_pkg::OP_JUMP_IF_SET |=> !rsp_valid ##1 !rsp_valid
      ##1 rsp_valid && rsp.jump) else $error("jump if set timing");
  jump_clear_a: assert property (take && flag_now && // [RQ4]
      cmd.op == cefu_pkg::OP_JUMP_IF_CLEAR |=> rsp_valid && !rsp.jump)
    else $error("jump if clear not taken");
  poll_copy_a: assert property (is_take_poll |=> rsp_valid && // [RQ5]
      rsp.c == $past(flag_now) && rsp.wr_c == $past(cmd.write_carry_flag))
    else $error("poll copy");
  poll_clear_a: assert property (is_take_poll |=> // [RQ11]
      flag_at(flags_q, $past(cmd.sel)) ==
      flag_at($past(set_v), $past(cmd.sel))) else $error("poll clear");
  pin_cfg_a: assert property (take && // [RQ6]
      cmd.op == cefu_pkg::OP_SET_PIN_MATCH |=> pin_high_q == $past(cmd.c_in)
      && pin_mask_q == $past(cmd.d)) else $error("pin match setup");
  sel_cfg_a: assert property (take && // [RQ8]
      cmd.op == cefu_pkg::OP_CONFIG_SELECT |=> sel_cfg_q[$past(cmd.sel[1:0])]
      == $past(cmd.d[8:0])) else $error("select config");
  wait_hold_a: assert property (state_q == cefu_pkg::ST_WAIT && // [RQ9]
      !wait_flag && !wait_tmo |=> !rsp_valid) else $error("wait ended early");
  wait_tmo_a: assert property (state_q == cefu_pkg::ST_WAIT && // [RQ10]
      !wait_flag && wait_tmo |=> rsp_valid && rsp.c && rsp.z)
    else $error("timeout not shown");
  ctr_match_a: assert property (system_counter == tgt_q[0] |=> // [RQ12]
      flags_q[`CEFU_FLAG_MATCH_BASE]) else $error("counter match");
  no_tmo_a: assert property (state_q == cefu_pkg::ST_WAIT && // [RQ13]
      wait_flag |=> rsp_valid && !rsp.c && !rsp.z)
    else $error("arrival shown as timeout");

  wait_flag_c: cover property (state_q == cefu_pkg::ST_WAIT ##1 rsp_valid);
  wait_tmo_c: cover property (state_q == cefu_pkg::ST_WAIT && wait_tmo);
  jump_c: cover property (take && jump_taken);
  irq_c: cover property (irq);
endmodule
`default_nettype wire

// [pkg/cefu_defines.svh]
// Constants of the event flag unit: flag slots, timing, register map.
// Assumes a 32-bit AXI4-Lite slave with byte addresses.
`ifndef CEFU_DEFINES_SVH
`define CEFU_DEFINES_SVH
`define CEFU_FLAG_ATTENTION 4'h0
`define CEFU_FLAG_MATCH_BASE 4'h1
`define CEFU_FLAG_FIFO_WRAP 4'h4
`define CEFU_FLAG_INTERRUPT 4'h5
`define CEFU_FLAG_PIN_MATCH 4'h6
`define CEFU_FLAG_QUEUE_EMPTY 4'h7
`define CEFU_FLAG_SELECT_BASE 4'h8
`define CEFU_FLAG_STREAM_BASE 4'hc
`define CEFU_JUMP_EXTRA 2'h2
`define CEFU_SEL_CFG_W 9
`define CEFU_SEL_MODE_HI 8
`define CEFU_SEL_MODE_LO 6
`define CEFU_REG_STATUS 8'h00
`define CEFU_REG_MASK 8'h04
`define CEFU_REG_FLAGS 8'h08
`define CEFU_REG_UNIT 8'h0c
`define CEFU_RESP_OKAY 2'h0
`define CEFU_RESP_SLVERR 2'h2
`define CEFU_ZERO32 32'h0000_0000
`endif

// [pkg/cefu_pkg.sv]
// Types shared by the event flag unit.
// Assumes the defines header is not needed here.
package cefu_pkg;
  typedef enum logic [3:0] {
    OP_ADVANCE_TARGET,
    OP_STROBE_ATTENTION,
    OP_JUMP_IF_SET,
    OP_JUMP_IF_CLEAR,
    OP_POLL_CLEAR,
    OP_SET_PIN_MATCH,
    OP_CONFIG_SELECT,
    OP_PREFIX_Q,
    OP_WAIT_CLEAR,
    OP_NONE
  } cefu_op_type;
  typedef struct packed {
    cefu_op_type op;
    logic [3:0] sel;
    logic [31:0] d;
    logic [31:0] s;
    logic write_carry_flag;
    logic write_zero_flag;
    logic c_in;
    logic z_in;
  } cefu_cmd_type;
  typedef struct packed {
    logic [31:0] result;
    logic wr_d;
    logic jump;
    logic [31:0] target;
    logic wr_c;
    logic c;
    logic wr_z;
    logic z;
  } cefu_rsp_type;
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_JUMP,
    ST_WAIT
  } cefu_state_type;
endpackage
